// ===== rtl/tcsc_pkg.sv
// tcsc_pkg: register map, field positions, reset values and timing counts
// for the timer clock-select and capture front end.
// assumes: an AXI4-Lite slave with 32-bit data, one register per word.
package tcsc_pkg;

  // ----------------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------------
  // timer_ctrl_b printed offset is not a multiple of four: index * 4
  localparam logic [7:0] TIMER_CTRL_B_IDX = 8'h81;
  localparam logic [11:0] TIMER_CTRL_B_ADDR = {2'b00, TIMER_CTRL_B_IDX, 2'b00};
  localparam logic [11:0] TIMER_CTRL_A_ADDR = 12'h0000;
  localparam logic [11:0] COUNT_ADDR = 12'h0010;
  localparam logic [11:0] CAPTURE_ADDR = 12'h0014;
  localparam logic [11:0] IRQ_STATUS_ADDR = 12'h0018;
  localparam logic [11:0] IRQ_MASK_ADDR = 12'h001c;

  // ----------------------------------------------------------------------
  // timer_ctrl_b fields
  // ----------------------------------------------------------------------
  localparam int CTRLB_FILTER_BIT = 7;
  localparam int CTRLB_EDGE_BIT = 6;
  localparam int CTRLB_RSVD_BIT = 5;
  localparam int CTRLB_WGM_HI_LSB = 3;
  localparam int CTRLB_CS_LSB = 0;
  localparam logic [7:0] TIMER_CTRL_B_RESET = 8'h00;
  localparam logic [7:0] TIMER_CTRL_B_WMASK = 8'hdf;
  localparam logic [1:0] TIMER_CTRL_A_RESET = 2'b00;

  // waveform modes (upper:lower) that use the capture register as top
  localparam logic [3:0] WGM_CAPTOP_A = 4'hc;
  localparam logic [3:0] WGM_CAPTOP_B = 4'he;
  localparam logic [3:0] WGM_CAPTOP_C = 4'h8;
  localparam logic [3:0] WGM_CAPTOP_D = 4'ha;

  // ----------------------------------------------------------------------
  // interrupt status bits
  // ----------------------------------------------------------------------
  localparam int IRQ_CAPTURE_BIT = 0;
  localparam int IRQ_OVERFLOW_BIT = 1;
  localparam int IRQ_WIDTH = 2;

  // ----------------------------------------------------------------------
  // clock select codes and counts
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    TCSC_CS_STOP,
    TCSC_CS_DIV1,
    TCSC_CS_DIV8,
    TCSC_CS_DIV64,
    TCSC_CS_DIV256,
    TCSC_CS_DIV1024,
    TCSC_CS_EXT_FALL,
    TCSC_CS_EXT_RISE
  } tcsc_cs_type;

  localparam int PRESCALE_WIDTH = 10;
  localparam int FILTER_SAMPLES = 4;
  localparam int COUNT_WIDTH = 16;

endpackage

// ===== rtl/tcsc_filter.sv
// tcsc_filter: capture-input noise filter, output follows the input only
// after a run of identical samples.
// assumes: input already synchronised to clk.
`timescale 1ns/1ps
module tcsc_filter #(
  parameter int SAMPLES = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic sample_in,
  output logic filt_out
);

  logic [SAMPLES-1:0] hist_q;
  logic filt_q;
  wire all_one = &hist_q;
  wire all_zero = ~|hist_q;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      hist_q <= '0;
      filt_q <= 1'b0;
    end
    else if (ce)
    begin
      hist_q <= {hist_q[SAMPLES-2:0], sample_in};
      if (all_one)
        filt_q <= 1'b1; // R01
      else if (all_zero)
        filt_q <= 1'b0; // R01
    end
  end

  assign filt_out = filt_q;

endmodule // tcsc_filter

// ===== rtl/tcsc_top.sv
// tcsc_top: clock-source selection, prescaler, 16-bit counter and input
// capture with an AXI4-Lite register slave and one interrupt line.
// assumes: ext_count_pin and capture_input_pin are asynchronous pins.
//
// How it works
// R01: filter enabled: capture input changes after four equal samples.
// R02: edge select zero picks falling capture edges, one picks rising.
// R03: capture edge copies counter into capture register, sets capture flag.
// R04: capture-as-top waveform modes disconnect the capture pin.
// R05: software writes zero to reserved bit 5; it reads back zero.
// R06: clock select 0 stops; 1..5 pick divide 1, 8, 64, 256, 1024.
// R07: codes 6 and 7 count external pin falling or rising edges.
// R08: external pin synchronised and edge detected, about three cycles late.
// R09: external clock half periods exceed one system clock cycle.
// R10: external clock should stay below system clock over 2.5.
// R11: switch external selection only while count pin is stable.
// R12: external edges advance counter directly, without prescaling.
// R13: control register bits 4:3 hold the upper waveform mode bits.
// R14: counter advances only on single-cycle enables in this clock domain.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module tcsc_top #(
  parameter int CW = 16,
  parameter int PW = 10
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic ext_count_pin,
  input wire logic capture_input_pin,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [7:0] timer_ctrl_b_q;
  logic [1:0] timer_ctrl_a_q;
  logic [CW-1:0] count_q;
  logic [CW-1:0] capture_value_reg_q;
  logic [tcsc_pkg::IRQ_WIDTH-1:0] irq_status_q;
  logic [tcsc_pkg::IRQ_WIDTH-1:0] irq_mask_q;
  logic [PW-1:0] prescale_q;

  wire capture_noise_filter_en = timer_ctrl_b_q[tcsc_pkg::CTRLB_FILTER_BIT];
  wire capture_edge_sel = timer_ctrl_b_q[tcsc_pkg::CTRLB_EDGE_BIT];
  wire [2:0] clock_select_field = timer_ctrl_b_q[tcsc_pkg::CTRLB_CS_LSB +: 3];
  wire [3:0] waveform_mode_bits =
    {timer_ctrl_b_q[tcsc_pkg::CTRLB_WGM_HI_LSB +: 2], timer_ctrl_a_q}; // R13

  // ----------------------------------------------------------------------
  // pin synchronisers: three stages, change seen when stages 2 and 3 agree
  // ----------------------------------------------------------------------
  logic [2:0] ext_sync_q;
  logic [2:0] cap_sync_q;
  logic ext_level_q;
  logic cap_level_q;

  // agreement moves the level at once: no extra flop of pin latency
  wire ext_level = (ext_sync_q[1] == ext_sync_q[2]) ? ext_sync_q[2]
    : ext_level_q; // R08
  wire cap_level = (cap_sync_q[1] == cap_sync_q[2]) ? cap_sync_q[2]
    : cap_level_q;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ext_sync_q <= 3'b000;
      cap_sync_q <= 3'b000;
      ext_level_q <= 1'b0;
      cap_level_q <= 1'b0;
    end
    else if (ce)
    begin
      ext_sync_q <= {ext_sync_q[1:0], ext_count_pin}; // R08
      cap_sync_q <= {cap_sync_q[1:0], capture_input_pin};
      ext_level_q <= ext_level; // R08
      cap_level_q <= cap_level;
    end
  end

  // edge detection: settled level against its registered copy
  wire ext_rise = ext_level & ~ext_level_q;
  wire ext_fall = ~ext_level & ext_level_q;

  // ----------------------------------------------------------------------
  // prescaler and count enable
  // ----------------------------------------------------------------------
  function automatic logic tap_hit(input logic [PW-1:0] p, input int bits);
    logic [PW-1:0] m;
    m = (PW'(1) << bits) - PW'(1);
    tap_hit = ((p & m) == m);
  endfunction

  logic count_en;
  always_comb
  begin
    count_en = 1'b0;
    case (tcsc_pkg::tcsc_cs_type'(clock_select_field))
      tcsc_pkg::TCSC_CS_STOP: count_en = 1'b0; // R06
      tcsc_pkg::TCSC_CS_DIV1: count_en = 1'b1; // R06
      tcsc_pkg::TCSC_CS_DIV8: count_en = tap_hit(prescale_q, 3); // R06
      tcsc_pkg::TCSC_CS_DIV64: count_en = tap_hit(prescale_q, 6); // R06
      tcsc_pkg::TCSC_CS_DIV256: count_en = tap_hit(prescale_q, 8); // R06
      tcsc_pkg::TCSC_CS_DIV1024: count_en = tap_hit(prescale_q, 10); // R06
      tcsc_pkg::TCSC_CS_EXT_FALL: count_en = ext_fall; // R07 R12
      tcsc_pkg::TCSC_CS_EXT_RISE: count_en = ext_rise; // R07 R12
      default: count_en = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // capture path
  // ----------------------------------------------------------------------
  logic cap_filt;
  logic cap_prev_q;

  tcsc_filter #(
    .SAMPLES(tcsc_pkg::FILTER_SAMPLES)
  ) u_filter (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .sample_in(cap_level),
    .filt_out(cap_filt)
  );

  wire cap_sel = capture_noise_filter_en ? cap_filt : cap_level; // R01
  wire cap_top_mode = (waveform_mode_bits == tcsc_pkg::WGM_CAPTOP_A) |
    (waveform_mode_bits == tcsc_pkg::WGM_CAPTOP_B) |
    (waveform_mode_bits == tcsc_pkg::WGM_CAPTOP_C) |
    (waveform_mode_bits == tcsc_pkg::WGM_CAPTOP_D);
  wire cap_edge = capture_edge_sel ? (cap_sel & ~cap_prev_q)
    : (~cap_sel & cap_prev_q); // R02
  wire cap_event = cap_edge & ~cap_top_mode; // R04
  wire ovf_event = count_en & (&count_q);

  // ----------------------------------------------------------------------
  // AXI4-Lite slave: single outstanding write and read
  // ----------------------------------------------------------------------
  logic aw_held_q;
  logic w_held_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] bresp_q;
  logic [1:0] rresp_q;

  assign s_axi_awready = ~aw_held_q & ~bvalid_q;
  assign s_axi_wready = ~w_held_q & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire wr_go = aw_held_q & w_held_q;

  wire [11:0] wa = awaddr_q;
  wire wr_ctrl_b = wr_go & wstrb_q[0] & (wa == tcsc_pkg::TIMER_CTRL_B_ADDR);
  wire wr_ctrl_a = wr_go & wstrb_q[0] & (wa == tcsc_pkg::TIMER_CTRL_A_ADDR);
  wire wr_stat = wr_go & wstrb_q[0] & (wa == tcsc_pkg::IRQ_STATUS_ADDR);
  wire wr_mask = wr_go & wstrb_q[0] & (wa == tcsc_pkg::IRQ_MASK_ADDR);
  wire wr_hit = (wa == tcsc_pkg::TIMER_CTRL_B_ADDR) |
    (wa == tcsc_pkg::TIMER_CTRL_A_ADDR) | (wa == tcsc_pkg::IRQ_STATUS_ADDR) |
    (wa == tcsc_pkg::IRQ_MASK_ADDR) | (wa == tcsc_pkg::COUNT_ADDR) |
    (wa == tcsc_pkg::CAPTURE_ADDR);

  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    if (s_axi_araddr == tcsc_pkg::TIMER_CTRL_B_ADDR)
      rd_mux = {24'h00_0000, timer_ctrl_b_q};
    else if (s_axi_araddr == tcsc_pkg::TIMER_CTRL_A_ADDR)
      rd_mux = {30'h000_0000, timer_ctrl_a_q};
    else if (s_axi_araddr == tcsc_pkg::COUNT_ADDR)
      rd_mux = {{(32-CW){1'b0}}, count_q};
    else if (s_axi_araddr == tcsc_pkg::CAPTURE_ADDR)
      rd_mux = {{(32-CW){1'b0}}, capture_value_reg_q};
    else if (s_axi_araddr == tcsc_pkg::IRQ_STATUS_ADDR)
      rd_mux = {30'h000_0000, irq_status_q};
    else if (s_axi_araddr == tcsc_pkg::IRQ_MASK_ADDR)
      rd_mux = {30'h000_0000, irq_mask_q};
    else
      rd_hit = 1'b0;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'b00;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'b00;
    end
    else if (ce)
    begin
      if (aw_take)
      begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take)
      begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? 2'b00 : 2'b10;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
      if (ar_take)
      begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= rd_hit ? 2'b00 : 2'b10;
      end
      else if (rvalid_q && s_axi_rready)
        rvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ----------------------------------------------------------------------
  // timer state
  // ----------------------------------------------------------------------
  // set wins over a write-one clear in the same cycle
  wire [tcsc_pkg::IRQ_WIDTH-1:0] irq_set = {ovf_event, cap_event};
  wire [tcsc_pkg::IRQ_WIDTH-1:0] irq_clr =
    wr_stat ? wdata_q[tcsc_pkg::IRQ_WIDTH-1:0] : '0;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      timer_ctrl_b_q <= tcsc_pkg::TIMER_CTRL_B_RESET;
      timer_ctrl_a_q <= tcsc_pkg::TIMER_CTRL_A_RESET;
      irq_mask_q <= '0;
      irq_status_q <= '0;
      prescale_q <= '0;
      count_q <= '0;
      capture_value_reg_q <= '0;
      cap_prev_q <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_ctrl_b)
        timer_ctrl_b_q <= wdata_q[7:0] & tcsc_pkg::TIMER_CTRL_B_WMASK; // R05
      if (wr_ctrl_a)
        timer_ctrl_a_q <= wdata_q[1:0]; // R13
      if (wr_mask)
        irq_mask_q <= wdata_q[tcsc_pkg::IRQ_WIDTH-1:0];
      irq_status_q <= (irq_status_q & ~irq_clr) | irq_set; // R03
      prescale_q <= prescale_q + 1'b1;
      if (count_en)
        count_q <= count_q + 1'b1; // R14
      if (cap_event)
        capture_value_reg_q <= count_q; // R03
      cap_prev_q <= cap_sel;
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);

endmodule // tcsc_top

// ===== tb/tcsc_pins.sv
// tcsc_pins: far-side pin model for the count and capture pins
// assumes: tasks are called from the bench, clk is the system clock
`timescale 1ns/1ps
module tcsc_pins (
  input wire logic clk,
  output logic ext_count_pin,
  output logic capture_input_pin
);
  initial
  begin
    ext_count_pin = 1'b0;
    capture_input_pin = 1'b0;
  end
  // three cycles a half period, safely below the sampling limit
  task automatic ext_toggle(input int k);
    repeat (k)
    begin
      @(posedge clk);
      ext_count_pin <= ~ext_count_pin;
      repeat (2) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask
  task automatic cap_drive(input logic v, input int n);
    @(posedge clk);
    capture_input_pin <= v;
    repeat (n) @(posedge clk);
  endtask
endmodule // tcsc_pins

// ===== tb/tcsc_assertions.sv
// tcsc_assertions: bus handshake and interrupt checks
// assumes: bound into tcsc_top, ce held high
`timescale 1ns/1ps
module tcsc_assertions #(
  parameter int CW = 16,
  parameter int PW = 10
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [11:0] rd_addr_q;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rd_addr_q <= 12'h000;
    else if (s_axi_arvalid && s_axi_arready)
      rd_addr_q <= s_axi_araddr;
  end
  // ------
  // properties
  // ------
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_answer;
    s_wr_take |-> ##2 s_axi_bvalid;
  endproperty
  property p_wr_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_wr_once;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  property p_rd_answer;
    s_rd_take |=> s_axi_rvalid;
  endproperty
  property p_rd_refuse;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_rd_once;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  property p_err_data;
    s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0000_0000;
  endproperty
  property p_ctrlb_read;
    s_axi_rvalid && rd_addr_q == tcsc_pkg::TIMER_CTRL_B_ADDR
      |-> s_axi_rdata[31:8] == 24'h00_0000 && !s_axi_rdata[5];
  endproperty
  // irq only drops through a register write
  property p_irq_fall;
    $fell(irq) |-> $rose(s_axi_bvalid);
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("no bvalid");
  a_wr_refuse: assert property (p_wr_refuse) else $error("aw/w ready");
  a_wr_once: assert property (p_wr_once) else $error("bvalid held");
  a_rd_answer: assert property (p_rd_answer) else $error("no rvalid");
  a_rd_refuse: assert property (p_rd_refuse) else $error("arready");
  a_rd_once: assert property (p_rd_once) else $error("rvalid held");
  a_err_data: assert property (p_err_data) else $error("err rdata");
  a_ctrlb_read: assert property (p_ctrlb_read)
    else $error("ctrl b read");
  a_irq_fall: assert property (p_irq_fall)
    else $error("irq fell");
endmodule // tcsc_assertions
bind tcsc_top tcsc_assertions #(.CW(CW), .PW(PW)) chk_u (
  .clk(clk), .rstn(rstn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));

// ===== tb/timer_clock_select_capture_tb.sv
// timer_clock_select_capture_tb: bus-driven bench with a pin model
// assumes: tcsc_top with default parameters, ce high except for one 50-edge freeze
`timescale 1ns/1ps
module timer_clock_select_capture_tb;
  localparam logic [11:0] A_CB = tcsc_pkg::TIMER_CTRL_B_ADDR;
  localparam logic [11:0] A_CA = tcsc_pkg::TIMER_CTRL_A_ADDR;
  localparam logic [11:0] A_CNT = tcsc_pkg::COUNT_ADDR;
  localparam logic [11:0] A_CAP = tcsc_pkg::CAPTURE_ADDR;
  localparam logic [11:0] A_ST = tcsc_pkg::IRQ_STATUS_ADDR;
  localparam logic [11:0] A_MK = tcsc_pkg::IRQ_MASK_ADDR;
  logic clk = 1'b0, rstn = 1'b0, ce = 1'b1;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, irq, ext_pin, cap_pin;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int err_count = 0, cmp_count = 0, seed = 236, cyc = 0;
  int dv[6] = '{0, 1, 8, 64, 256, 1024};
  always #2.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  tcsc_top dut_u (.clk(clk), .rstn(rstn), .ce(ce),
    .ext_count_pin(ext_pin), .capture_input_pin(cap_pin),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq(irq));
  tcsc_pins pins_u (.clk(clk), .ext_count_pin(ext_pin),
    .capture_input_pin(cap_pin));
  // ------
  // tasks
  // ------
  task automatic finish_test();
    if (err_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input int lo, input int hi);
    cmp_count++;
    if ($isunknown(got) || got < lo || got > hi)
    begin
      err_count++;
      $display("[ERR] %0t got %h want %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input int er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    repeat (40)
    begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        bready <= 1'b0;
        chk(32'(bresp), er, er);
        return;
      end
    end
    err_count++;
    finish_test();
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, input int er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    repeat (40)
    begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        rready <= 1'b0;
        d = rdata;
        chk(32'(rresp), er, er);
        return;
      end
    end
    err_count++;
    finish_test();
  endtask
  task automatic rc(input logic [11:0] a, input int lo, input int hi);
    logic [31:0] v;
    rd(a, v, 0);
    chk(v, lo, hi);
  endtask
  // ------
  // main sequence
  // ------
  initial
  begin
    logic [31:0] v, c;
    int d, e, f, t;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rc(A_CB, 0, 0);
    rc(A_CNT, 0, 0);
    rc(A_ST, 0, 0);
    rd(12'h100, v, 2);
    wr(12'h100, 32'h0000_00ff, 2);
    v = $random(seed);
    v[5] = 1'b0;
    wstrb <= 4'h0;
    wr(A_CB, v, 0);
    wstrb <= 4'hf;
    rc(A_CB, 0, 0);
    wr(A_CB, v, 0);
    rc(A_CB, int'(v[7:0] & 8'hdf), int'(v[7:0] & 8'hdf));
    wr(A_CB, 0, 0);
    // prescaler taps: free-running phase allows a small slack
    for (d = 0; d < 6; d++)
    begin
      rd(A_CNT, c, 0);
      wr(A_CB, 32'(d), 0);
      e = cyc;
      repeat (4096) @(posedge clk);
      wr(A_CB, 0, 0);
      f = cyc;
      rd(A_CNT, v, 0);
      e = (d == 0) ? 0 : (f - e) / dv[d];
      t = (d == 0) ? 0 : 2;
      chk(v - c, e - t, e + t);
    end
    // clock enable low for 50 edges freezes the counter
    rd(A_CNT, c, 0);
    wr(A_CB, 1, 0);
    e = cyc;
    ce <= 1'b0;
    repeat (50) @(posedge clk);
    ce <= 1'b1;
    wr(A_CB, 0, 0);
    f = cyc;
    rd(A_CNT, v, 0);
    chk(v - c, f - e - 50, f - e - 50);
    // five toggles from low: three rising, two falling edges
    for (d = 6; d < 8; d++)
    begin
      rd(A_CNT, c, 0);
      wr(A_CB, 32'(d), 0);
      pins_u.ext_toggle(5);
      wr(A_CB, 0, 0);
      rd(A_CNT, v, 0);
      chk(v - c, d - 4, d - 4);
      pins_u.ext_toggle(1);
    end
    // counter stopped, so the capture value is known exactly
    wr(A_MK, 1, 0);
    rd(A_CNT, c, 0);
    for (f = 0; f < 2; f++)
      for (e = 0; e < 2; e++)
      begin
        pins_u.cap_drive(e[0], 10);
        wr(A_CB, 32'(f * 128 + e * 64), 0);
        wr(A_ST, 3, 0);
        chk(32'(irq), 0, 0);
        pins_u.cap_drive(!e[0], 10);
        rc(A_ST, 0, 0);
        pins_u.cap_drive(e[0], 2);
        pins_u.cap_drive(!e[0], 10);
        rc(A_ST, 1 - f, 1 - f);
        wr(A_ST, 1, 0);
        pins_u.cap_drive(e[0], 10);
        rc(A_ST, 1, 1);
        chk(32'(irq), 1, 1);
        rc(A_CAP, int'(c), int'(c));
      end
    wr(A_MK, 0, 0);
    chk(32'(irq), 0, 0);
    for (f = 8; f < 16; f += 2)
    begin
      wr(A_CA, 32'(f % 4), 0);
      wr(A_CB, 32'(64 + (f / 4) * 8), 0);
      wr(A_ST, 3, 0);
      pins_u.cap_drive(1'b0, 10);
      pins_u.cap_drive(1'b1, 10);
      rc(A_ST, 0, 0);
    end
    finish_test();
  end
endmodule // timer_clock_select_capture_tb
